// ==== clk_fanout_ctrl.sv ====
// file: control register bank of the differential clock fan-out buffer
`timescale 1ns/100ps
`default_nettype none
module clk_fanout_ctrl #(
  parameter int num_outputs = 12
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // one-time-programmable defaults
  input wire clk_fanout_pkg::otp_defaults_type otp,
  // address strap pins
  input wire logic strap_addr_low,
  input wire logic strap_addr_high,
  // register access from the management bus engine
  input wire clk_fanout_pkg::reg_req_type req,
  output logic [7:0] rdata,
  // client address for the bus engine
  output logic [6:0] client_addr,
  // output drivers
  output clk_fanout_pkg::leg_ctrl_type [11:0] legs,
  // second differential input control
  output logic [3:0] second_input_bias,
  output logic second_input_sleep,
  output logic second_input_coupling
);
  ////////////////////////////////////////////////////////////////////////////
  // strap synchronisers
  logic [1:0] strap_meta_ff;
  logic [1:0] strap_sync_ff;
  logic [1:0] nxt_strap_meta;
  logic [1:0] nxt_strap_sync;

  // two-stage capture of the strap pins
  always_comb begin
    nxt_strap_meta = {strap_addr_high, strap_addr_low};
    nxt_strap_sync = strap_meta_ff;
  end

  always_ff @(posedge sys_clk) begin
    strap_meta_ff <= nxt_strap_meta;
    strap_sync_ff <= nxt_strap_sync;
  end

  ////////////////////////////////////////////////////////////////////////////
  // register storage
  logic [7:0] enable_low_ff;
  logic [3:0] enable_high_ff;
  logic [1:0] idle8_ff;
  logic [1:0] idle9_ff;
  logic [1:0] addr_bits_ff;
  logic [3:0] bias_ff;
  logic sleep_ff;
  logic coupling_ff;
  logic load_otp_ff;
  logic [7:0] nxt_enable_low;
  logic [3:0] nxt_enable_high;
  logic [1:0] nxt_idle8;
  logic [1:0] nxt_idle9;
  logic [1:0] nxt_addr_bits;
  logic [3:0] nxt_bias;
  logic nxt_sleep;
  logic nxt_coupling;

  function automatic logic hit(input clk_fanout_pkg::reg_req_type r, input logic [7:0] off);
    hit = r.wr_en && (r.addr == off);
  endfunction

  // register writes; otp defaults load in the first cycle after reset release
  always_comb begin
    nxt_enable_low = enable_low_ff;
    nxt_enable_high = enable_high_ff;
    nxt_idle8 = idle8_ff;
    nxt_idle9 = idle9_ff;
    nxt_addr_bits = addr_bits_ff;
    nxt_bias = bias_ff;
    nxt_sleep = sleep_ff;
    nxt_coupling = coupling_ff;
    if (load_otp_ff) begin
      nxt_addr_bits = otp.addr_bits;
      nxt_bias = otp.bias;
    end
    if (hit(req, clk_fanout_pkg::enable_low_off)) begin
      nxt_enable_low = req.wdata;
    end
    if (hit(req, clk_fanout_pkg::enable_high_off)) begin
      nxt_enable_high = req.wdata[clk_fanout_pkg::enable_high_bits-1:0];
    end
    if (hit(req, clk_fanout_pkg::idle_high_off)) begin
      nxt_idle8 = req.wdata[clk_fanout_pkg::idle_out8_lsb +: 2];
      nxt_idle9 = req.wdata[clk_fanout_pkg::idle_out9_lsb +: 2];
    end
    if (hit(req, clk_fanout_pkg::client_addr_off)) begin
      nxt_addr_bits = req.wdata[1:0];
    end
    if (hit(req, clk_fanout_pkg::second_input_off)) begin
      nxt_bias = req.wdata[clk_fanout_pkg::bias_lsb +: 4];
      nxt_sleep = req.wdata[clk_fanout_pkg::sleep_bit];
      nxt_coupling = req.wdata[clk_fanout_pkg::coupling_bit];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      enable_low_ff <= clk_fanout_pkg::enable_rst;
      enable_high_ff <= clk_fanout_pkg::enable_rst[3:0];
      idle8_ff <= clk_fanout_pkg::idle_rst;
      idle9_ff <= clk_fanout_pkg::idle_rst;
      addr_bits_ff <= 2'h0;
      bias_ff <= 4'h0;
      {sleep_ff, coupling_ff} <= clk_fanout_pkg::sleep_coupling_rst;
      load_otp_ff <= 1'b1;
    end else begin
      enable_low_ff <= nxt_enable_low;
      enable_high_ff <= nxt_enable_high;
      idle8_ff <= nxt_idle8;
      idle9_ff <= nxt_idle9;
      addr_bits_ff <= nxt_addr_bits;
      bias_ff <= nxt_bias;
      sleep_ff <= nxt_sleep;
      coupling_ff <= nxt_coupling;
      load_otp_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux; unused bits read zero
  always_comb begin
    rdata = 8'h00;
    case (req.addr)
      clk_fanout_pkg::idle_high_off: rdata = {4'h0, idle9_ff, idle8_ff};
      clk_fanout_pkg::enable_low_off: rdata = enable_low_ff;
      clk_fanout_pkg::enable_high_off: rdata = {4'h0, enable_high_ff};
      clk_fanout_pkg::client_addr_off: rdata = {6'h00, addr_bits_ff};
      clk_fanout_pkg::identity_off: rdata = {1'b0, otp.revision, otp.part_code};
      clk_fanout_pkg::second_input_off: rdata = {2'h0, bias_ff, sleep_ff, coupling_ff};
      default: rdata = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // client address and second input outputs
  assign client_addr = {clk_fanout_pkg::addr_prefix, addr_bits_ff, strap_sync_ff[1], strap_sync_ff[0]};
  assign second_input_bias = bias_ff;
  assign second_input_sleep = sleep_ff;
  assign second_input_coupling = coupling_ff;

  ////////////////////////////////////////////////////////////////////////////
  // per-output drive; idle fields outside this bank treated as both low
  logic [11:0] enables;
  assign enables = {enable_high_ff, enable_low_ff};

  genvar gi;
  generate
    for (gi = 0; gi < 12; gi++) begin : g_out
      logic [1:0] sel;
      assign sel = (gi == 8) ? idle8_ff : (gi == 9) ? idle9_ff : clk_fanout_pkg::idle_both_low;
      if (gi < num_outputs) begin : g_on
        clk_out_leg u_leg (
          .enable(enables[gi]),
          .idle_sel(sel),
          .leg(legs[gi])
        );
      end else begin : g_off
        assign legs[gi] = '0;
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ==== clk_fanout_pkg.sv ====
// package: register map, field layout, reset values and carriers of the fan-out control bank
package clk_fanout_pkg;
  // register offsets
  localparam logic [7:0] idle_high_off = 8'h07;
  localparam logic [7:0] enable_low_off = 8'h08;
  localparam logic [7:0] enable_high_off = 8'h09;
  localparam logic [7:0] client_addr_off = 8'h0a;
  localparam logic [7:0] identity_off = 8'h0b;
  localparam logic [7:0] second_input_off = 8'h0d;
  // field positions
  localparam int idle_out8_lsb = 0;
  localparam int idle_out9_lsb = 2;
  localparam int enable_high_bits = 4;
  localparam int bias_lsb = 2;
  localparam int sleep_bit = 1;
  localparam int coupling_bit = 0;
  localparam int rev_lsb = 3;
  // reset values
  localparam logic [7:0] enable_rst = 8'h00;
  localparam logic [1:0] idle_rst = 2'h0;
  localparam logic [1:0] sleep_coupling_rst = 2'h0;
  // fixed upper part of the client address
  localparam logic [2:0] addr_prefix = 3'h3;
  // idle-state encodings
  localparam logic [1:0] idle_both_low = 2'h0;
  localparam logic [1:0] idle_drive_low = 2'h1;
  // one-time-programmable defaults
  typedef struct packed {
    logic [1:0] addr_bits;
    logic [3:0] revision;
    logic [2:0] part_code;
    logic [3:0] bias;
  } otp_defaults_type;
  // drive state of one differential leg pair
  typedef struct packed {
    logic true_out;
    logic comp_out;
    logic true_oe;
    logic comp_oe;
    logic active;
  } leg_ctrl_type;
  // management bus register access
  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_type;
endpackage

// ==== clk_out_leg.sv ====
// file: leg control for one differential clock output
`timescale 1ns/100ps
`default_nettype none
module clk_out_leg (
  // control
  input wire logic enable,
  input wire logic [1:0] idle_sel,
  // drive
  output clk_fanout_pkg::leg_ctrl_type leg
);
  // active low-power drive when enabled, else idle pattern
  always_comb begin
    leg = '0;
    if (enable) begin
      leg.active = 1'b1;
      leg.true_oe = 1'b1;
      leg.comp_oe = 1'b1;
    end else begin
      case (idle_sel)
        clk_fanout_pkg::idle_both_low: begin
          leg.true_oe = 1'b1;
          leg.comp_oe = 1'b1;
        end
        clk_fanout_pkg::idle_drive_low: begin
          leg.true_oe = 1'b1;
          leg.comp_oe = 1'b1;
          leg.comp_out = 1'b1;
        end
        default: begin
          leg = '0;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== fanout_chk.sv ====
// checker: port relations of the fan-out control bank
`timescale 1ns/100ps
`default_nettype none
module fanout_chk #(
  parameter int num_outputs = 12
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // inputs
  input wire clk_fanout_pkg::otp_defaults_type otp,
  input wire clk_fanout_pkg::reg_req_type req,
  // outputs
  input wire logic [7:0] rdata,
  input wire logic [6:0] client_addr,
  input wire clk_fanout_pkg::leg_ctrl_type [11:0] legs,
  input wire logic [3:0] second_input_bias,
  input wire logic second_input_sleep,
  input wire logic second_input_coupling
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire wr = req.wr_en;
  ////////////////////////////////////////////////////////////////
  AST_EN0: assert property (wr && req.addr == 8'h08 |=> legs[0].active == $past(req.wdata[0]))
    else $error("enable 0 not applied");
  AST_ON_OE: assert property (legs[0].active |-> legs[0].true_oe && legs[0].comp_oe)
    else $error("active output not driven");
  AST_EN8: assert property (num_outputs > 8 && wr && req.addr == 8'h09 |=> legs[8].active == $past(req.wdata[0]))
    else $error("enable 8 not applied");
  AST_RST_OFF: assert property ($fell(rst) |-> !legs[0].active && !legs[11].active)
    else $error("output on after reset");
  AST_IDLE8: assert property (wr && req.addr == 8'h07 && req.wdata[1:0] == 2'h1 && !legs[8].active
    |=> legs[8].comp_out && !legs[8].true_out)
    else $error("drive-low idle wrong");
  AST_HIZ9: assert property (wr && req.addr == 8'h07 && req.wdata[3] && !legs[9].active
    |=> !legs[9].true_oe && !legs[9].comp_oe)
    else $error("high-z idle wrong");
  AST_PREFIX: assert property (client_addr[6:4] == 3'h3)
    else $error("address prefix wrong");
  AST_OTP: assert property ($fell(rst) && !wr |=> client_addr[3:2] == $past(otp.addr_bits)
    && second_input_bias == $past(otp.bias))
    else $error("otp default not loaded");
  AST_ID: assert property (req.addr == 8'h0b |-> rdata == {1'b0, otp.revision, otp.part_code})
    else $error("identity read wrong");
  AST_IN2: assert property (wr && req.addr == 8'h0d |=> second_input_bias == $past(req.wdata[5:2])
    && {second_input_sleep, second_input_coupling} == $past(req.wdata[1:0]))
    else $error("second input control wrong");
  AST_UNUSED: assert property (req.addr == 8'h0a |-> rdata[7:2] == 6'h00)
    else $error("unused bits read nonzero");
  // main scenarios
  cover property (wr && req.addr == 8'h09);
  cover property (wr && req.addr == 8'h0d);
  cover property (req.rd_en && req.addr == 8'h0b);
endmodule
bind clk_fanout_ctrl fanout_chk #(.num_outputs(num_outputs)) fanout_chk_i (.sys_clk(sys_clk), .rst(rst),
  .otp(otp), .req(req), .rdata(rdata), .client_addr(client_addr), .legs(legs),
  .second_input_bias(second_input_bias), .second_input_sleep(second_input_sleep),
  .second_input_coupling(second_input_coupling));
`default_nettype wire

// ==== mgmt_host.sv ====
// management bus host model driving register requests
`timescale 1ns/100ps
`default_nettype none
module mgmt_host (
  // clock
  input wire logic sys_clk,
  // register access
  input wire logic [7:0] rdata,
  output var clk_fanout_pkg::reg_req_type req
);
  initial req = '0;
  // one-cycle write pulse; reserved enable bits always sent as zero
  // returns at the falling edge so that the registered result has settled
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    req <= '{1'b1, 1'b0, a, (a == 8'h09) ? (d & 8'h0f) : d};
    @(posedge sys_clk);
    req <= '0;
    @(negedge sys_clk);
  endtask
  // read held for one cycle, data taken at the closing edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge sys_clk);
    d = rdata;
    req <= '0;
  endtask
endmodule
`default_nettype wire

// ==== tb.sv ====
// testbench: register and output checks of the fan-out control bank
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic sys_clk;
  logic rst;
  logic [7:0] rdata;
  logic [6:0] client_addr;
  clk_fanout_pkg::leg_ctrl_type [11:0] legs;
  clk_fanout_pkg::reg_req_type req;
  clk_fanout_pkg::otp_defaults_type otp;
  logic [3:0] bias;
  logic sleep;
  logic coupling;
  int err_total;
  int checked;
  // revision 6 and part code 5 are arbitrary
  assign otp = '{2'h1, 4'h6, 3'h5, 4'ha};
  clk_fanout_ctrl #(.num_outputs(12)) clk_fanout_ctrl_i (.sys_clk(sys_clk), .rst(rst), .otp(otp),
    .strap_addr_low(1'b1), .strap_addr_high(1'b0), .req(req), .rdata(rdata), .client_addr(client_addr),
    .legs(legs), .second_input_bias(bias), .second_input_sleep(sleep), .second_input_coupling(coupling));
  mgmt_host mgmt_host_i (.sys_clk(sys_clk), .rdata(rdata), .req(req));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    mgmt_host_i.rd(a, d);
    chk(d, exp);
  endtask
  task automatic t_reset;
    rchk(8'h08, 8'h00);
    rchk(8'h07, 8'h00);
    rchk(8'h0a, 8'h01);
    rchk(8'h0d, 8'h28);
    chk({1'b0, client_addr}, 8'h35);
  endtask
  task automatic t_first_clock_out;
    mgmt_host_i.wr(8'h08, 8'h01);
    chk({5'h0, legs[0].active, legs[0].true_oe, legs[0].comp_oe}, 8'h07);
    mgmt_host_i.wr(8'h08, 8'h00);
    chk({3'h0, legs[0]}, 8'h06);
  endtask
  task automatic t_high;
    mgmt_host_i.wr(8'h07, 8'h0d);
    mgmt_host_i.wr(8'h09, 8'h02);
    rchk(8'h09, 8'h02);
    chk({3'h0, legs[8]}, 8'h0e);
    chk({7'h0, legs[9].active}, 8'h01);
    mgmt_host_i.wr(8'h09, 8'h00);
    chk({3'h0, legs[9]}, 8'h00);
  endtask
  task automatic t_id;
    mgmt_host_i.wr(8'h0b, 8'hff);
    rchk(8'h0b, 8'h35);
    mgmt_host_i.wr(8'h0a, 8'hff);
    rchk(8'h0a, 8'h03);
    chk({1'b0, client_addr}, 8'h3d);
    rchk(8'h20, 8'h00);
  endtask
  task automatic t_in2;
    mgmt_host_i.wr(8'h0d, 8'hff);
    rchk(8'h0d, 8'h3f);
    chk({2'h0, bias, sleep, coupling}, 8'h3f);
    mgmt_host_i.wr(8'h0d, 8'h00);
    chk({2'h0, bias, sleep, coupling}, 8'h00);
  endtask
  task automatic end_sim;
    $display("errors %0d checks %0d", err_total, checked);
    if (err_total == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // watchdog well beyond the expected run
  initial begin
    #20000;
    err_total++;
    end_sim();
  end
  initial begin
    rst = 1'b1;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset();
    t_first_clock_out();
    t_high();
    t_id();
    t_in2();
    end_sim();
  end
endmodule
`default_nettype wire
